// File: hw/dsp_mac_map.vh
// Purpose: Constants for the multiply-accumulate arithmetic slice.
// Assumes: Included by the slice's design file, its checker and its bench.
// Notes:   Definitions only.
`ifndef DSP_MAC_MAP_VH
`define DSP_MAC_MAP_VH

// =========================================================
// Element kinds
`define KIND_PLAIN_MULTIPLY_ELEMENT   2'd0
`define KIND_MAC    2'd1
`define KIND_ADDSUB 2'd2
`define KIND_SUM    2'd3

// =========================================================
// Operand width selection
`define WSEL_9      2'd0
`define WSEL_18     2'd1
`define WSEL_36     2'd2

// =========================================================
// Bus widths and reset values
`define OPW         72
`define RESW        144
`define ACCW        72
`define OP_RST      72'h0
`define RES_RST     144'h0
`define ACC_RST     72'h0

// =========================================================
// Stage indices in the enable and select vectors
`define STG_IN      0
`define STG_PIPE    1
`define STG_OUT     2

`endif

// File: hw/dsp_multiply_accumulate_block.v
// Purpose: Configurable multiply / multiply-accumulate / sum-of-products slice.
// Assumes: Fabric operands and controls are synchronous to core_clk.
// Notes:   Stage clock sources are sampled pins; a stage ticks on their rising edge.
`timescale 1ns/1ps
`include "dsp_mac_map.vh"

// How it works
// - Widths 9, 18, 36; one signedness
// - One operand width for whole block
// - Four element kinds selectable
// - Instance counts per width; no 36 combos
// - Operand register loads direct or shifts
// - Dynamic signed/unsigned every cycle
// - Dynamic accumulator add/subtract every cycle
// - Dynamic parallel or serial loading
// - Plain multiply, optional registers
// - Accumulate into always-present output register
// - Accumulator loadable at run time
// - A0*B0 plus or minus A1*B1
// - Second pair A2*B2 +/- A3*B3
// - Summation adds both pair results
// - Each stage picks one of four clocks
// - Each stage picks enable and reset
// - Roll-over detection, signed and unsigned
// - Overflow is one registered cycle pulse
module dsp_multiply_accumulate_block (
  input  wire         core_clk,
  input  wire         sys_rst,
  input  wire [1:0]   cfg_kind,
  input  wire [1:0]   cfg_width,
  input  wire         cfg_signed,
  input  wire         cfg_sub,
  input  wire         cfg_serial,
  input  wire         dyn_en,
  input  wire         sign_ctrl,
  input  wire         addsub_ctrl,
  input  wire         serial_ctrl,
  input  wire         acc_load,
  input  wire [143:0] acc_init,
  input  wire [71:0]  a_in,
  input  wire [71:0]  b_in,
  input  wire [35:0]  a_shift_in,
  input  wire [35:0]  b_shift_in,
  input  wire [2:0]   stage_use,
  input  wire [5:0]   clk_sel,
  input  wire [5:0]   ce_sel,
  input  wire [5:0]   rst_sel,
  input  wire         stage_clock_source_0,
  input  wire         stage_clock_source_1,
  input  wire         stage_clock_source_2,
  input  wire         stage_clock_source_3,
  input  wire         stage_enable_source_0,
  input  wire         stage_enable_source_1,
  input  wire         stage_enable_source_2,
  input  wire         stage_enable_source_3,
  input  wire         stage_reset_source_0,
  input  wire         stage_reset_source_1,
  input  wire         stage_reset_source_2,
  input  wire         stage_reset_source_3,
  output reg  [143:0] result_out,
  output reg  [1:0]   overflow_out,
  output reg          cfg_error
);

  // =======================================================
  // Stage clock source sampling
  reg  [3:0]      clk_s1_reg;
  reg  [3:0]      clk_s2_reg;
  reg  [3:0]      clk_s3_reg;
  wire [3:0]      clk_rise;
  wire [3:0]      ce_vec;
  wire [3:0]      rst_vec;
  wire [2:0]      tick;
  wire [2:0]      clr;

  // Sources are pins: two flops first, a third one for the edge
  // Rises two or more clocks apart give single-cycle ticks
  assign clk_rise = clk_s2_reg & ~clk_s3_reg;
  assign ce_vec   = {stage_enable_source_3, stage_enable_source_2,
                     stage_enable_source_1, stage_enable_source_0};
  assign rst_vec  = {stage_reset_source_3, stage_reset_source_2,
                     stage_reset_source_1, stage_reset_source_0};

  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_stage
      assign tick[s] = clk_rise[clk_sel[2*s+1:2*s]] & ce_vec[ce_sel[2*s+1:2*s]];
      assign clr[s]  = clk_rise[clk_sel[2*s+1:2*s]] & rst_vec[rst_sel[2*s+1:2*s]];
    end
  endgenerate

  // =======================================================
  // Dynamic controls
  wire            is_mac;
  wire            sgn;
  wire            sub;
  wire            serial;
  wire [2:0]      use_eff;

  // Controls act in the cycle a stage computes, not pipelined
  assign is_mac  = (cfg_kind == `KIND_MAC);
  assign sgn     = dyn_en ? sign_ctrl : cfg_signed;
  assign sub     = dyn_en ? addsub_ctrl : cfg_sub;
  assign serial  = dyn_en ? serial_ctrl : cfg_serial;
  assign use_eff = {stage_use[`STG_OUT] | is_mac, stage_use[`STG_PIPE:`STG_IN]};

  // =======================================================
  // Input operand stage
  reg  [`OPW-1:0] a_reg;
  reg  [`OPW-1:0] b_reg;
  reg  [`OPW-1:0] a_next;
  reg  [`OPW-1:0] b_next;
  wire [`OPW-1:0] a_op;
  wire [`OPW-1:0] b_op;

  always @* begin
    a_next = a_in;
    b_next = b_in;
    if (serial) begin
      if (cfg_width == `WSEL_9) begin
        a_next = {a_reg[62:0], a_shift_in[8:0]};
        b_next = {b_reg[62:0], b_shift_in[8:0]};
      end else if (cfg_width == `WSEL_18) begin
        a_next = {a_reg[53:0], a_shift_in[17:0]};
        b_next = {b_reg[53:0], b_shift_in[17:0]};
      end else begin
        a_next = {a_reg[35:0], a_shift_in};
        b_next = {b_reg[35:0], b_shift_in};
      end
    end
  end

  assign a_op = use_eff[`STG_IN] ? a_reg : a_in;
  assign b_op = use_eff[`STG_IN] ? b_reg : b_in;

  // =======================================================
  // Multipliers for each width
  wire [143:0]    p9;
  wire [143:0]    p18;
  wire [71:0]     p36;
  wire [575:0]    e9;
  wire [287:0]    e18;

  // Operands widened by one bit so that one signed multiply
  // serves both signed and unsigned lanes
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_m9
      wire signed [9:0]  xa = {sgn & a_op[9*i+8], a_op[9*i+8:9*i]};
      wire signed [9:0]  xb = {sgn & b_op[9*i+8], b_op[9*i+8:9*i]};
      wire signed [19:0] xp = xa * xb;
      assign p9[18*i+17:18*i] = xp[17:0];
    end
    for (i = 0; i < 4; i = i + 1) begin : g_m18
      wire signed [18:0] xa = {sgn & a_op[18*i+17], a_op[18*i+17:18*i]};
      wire signed [18:0] xb = {sgn & b_op[18*i+17], b_op[18*i+17:18*i]};
      wire signed [37:0] xp = xa * xb;
      assign p18[36*i+35:36*i] = xp[35:0];
    end
  endgenerate

  wire signed [36:0] xa36 = {sgn & a_op[35], a_op[35:0]};
  wire signed [36:0] xb36 = {sgn & b_op[35], b_op[35:0]};
  wire signed [73:0] xp36 = xa36 * xb36;
  assign p36 = xp36[71:0];

  // =======================================================
  // Pipeline stage
  reg  [143:0]    p_reg;
  reg  [143:0]    p_now;
  wire [143:0]    p_op;

  always @* begin
    if (cfg_width == `WSEL_9) begin
      p_now = p9;
    end else if (cfg_width == `WSEL_18) begin
      p_now = p18;
    end else begin
      p_now = {72'h0, p36};
    end
  end

  assign p_op = use_eff[`STG_PIPE] ? p_reg : p_now;

  generate
    for (i = 0; i < 8; i = i + 1) begin : g_e9
      assign e9[72*i+71:72*i] = {{54{sgn & p_op[18*i+17]}}, p_op[18*i+17:18*i]};
    end
    for (i = 0; i < 4; i = i + 1) begin : g_e18
      assign e18[72*i+71:72*i] = {{36{sgn & p_op[36*i+35]}}, p_op[36*i+35:36*i]};
    end
  endgenerate

  // =======================================================
  // Add/subtract pairs and summation
  wire [287:0]    as9;
  wire [143:0]    as18;
  wire [143:0]    sm9;
  wire [71:0]     sm18;

  generate
    for (i = 0; i < 4; i = i + 1) begin : g_as9
      assign as9[72*i+71:72*i] = sub ? e9[144*i+71:144*i] - e9[144*i+143:144*i+72]
                                     : e9[144*i+71:144*i] + e9[144*i+143:144*i+72];
    end
    for (i = 0; i < 2; i = i + 1) begin : g_as18
      assign as18[72*i+71:72*i] = sub ? e18[144*i+71:144*i] - e18[144*i+143:144*i+72]
                                      : e18[144*i+71:144*i] + e18[144*i+143:144*i+72];
      assign sm9[72*i+71:72*i] = as9[144*i+71:144*i] + as9[144*i+143:144*i+72];
    end
  endgenerate
  assign sm18 = as18[71:0] + as18[143:72];

  // =======================================================
  // Accumulators
  reg  [143:0]    out_reg;
  wire [143:0]    acc_next;
  wire [1:0]      ovf_ev;

  // Accumulated value lives in the output stage register
  // Subtract adds the inverted product plus one
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_acc
      wire [71:0] prev = out_reg[72*i+71:72*i];
      wire [71:0] prod = (cfg_width == `WSEL_9) ? e9[72*i+71:72*i] : e18[72*i+71:72*i];
      wire [71:0] opd  = sub ? ~prod : prod;
      wire [72:0] tot  = {1'b0, prev} + {1'b0, opd} + {72'h0, sub};
      assign acc_next[72*i+71:72*i] = acc_load ? acc_init[72*i+71:72*i] : tot[71:0];
      assign ovf_ev[i] = ~acc_load & (sgn ? ((prev[71] == opd[71]) & (tot[71] != prev[71]))
                                          : (tot[72] ^ sub));
    end
  endgenerate

  // =======================================================
  // Result selection
  // Pairs keep the low 36 bits of each sum at width 9
  reg  [143:0]    res_now;

  always @* begin
    res_now = `RES_RST;
    case (cfg_kind)
      `KIND_PLAIN_MULTIPLY_ELEMENT: begin
        res_now = p_op;
      end
      `KIND_MAC: begin
        res_now = acc_next;
      end
      `KIND_ADDSUB: begin
        if (cfg_width == `WSEL_9) begin
          res_now = {as9[251:216], as9[179:144], as9[107:72], as9[35:0]};
        end else begin
          res_now = as18;
        end
      end
      default: begin
        if (cfg_width == `WSEL_9) begin
          res_now = sm9;
        end else begin
          res_now = {{72{sgn & sm18[71]}}, sm18};
        end
      end
    endcase
  end

  // =======================================================
  // Registers
  // Stage clear beats enable; every stage follows one tick rule
  // Input, pipe and output stages sharing a source form a true pipeline
  always @(posedge core_clk) begin
    if (sys_rst) begin
      clk_s1_reg   <= 4'h0;
      clk_s2_reg   <= 4'h0;
      clk_s3_reg   <= 4'h0;
      a_reg        <= `OP_RST;
      b_reg        <= `OP_RST;
      p_reg        <= `RES_RST;
      out_reg      <= `RES_RST;
      result_out   <= `RES_RST;
      overflow_out <= 2'b00;
      cfg_error    <= 1'b0;
    end else begin
      clk_s1_reg <= {stage_clock_source_3, stage_clock_source_2,
                     stage_clock_source_1, stage_clock_source_0};
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      if (clr[`STG_IN]) begin
        a_reg <= `OP_RST;
        b_reg <= `OP_RST;
      end else if (tick[`STG_IN]) begin
        a_reg <= a_next;
        b_reg <= b_next;
      end
      if (clr[`STG_PIPE]) begin
        p_reg <= `RES_RST;
      end else if (tick[`STG_PIPE]) begin
        p_reg <= p_now;
      end
      if (clr[`STG_OUT]) begin
        out_reg <= `RES_RST;
      end else if (tick[`STG_OUT]) begin
        out_reg <= res_now;
      end
      // Pulse only on a real output tick, never on a clear
      // one pulse per roll-over
      if (is_mac & tick[`STG_OUT] & ~clr[`STG_OUT]) begin
        overflow_out <= ovf_ev;
      end else begin
        overflow_out <= 2'b00;
      end
      // Extra flop keeps every output registered
      result_out <= use_eff[`STG_OUT] ? out_reg : res_now;
      // Illegal setups still compute and are only flagged
      // no combined kinds at width 36
      cfg_error  <= (cfg_width == 2'd3) |
                    ((cfg_width == `WSEL_36) & (cfg_kind != `KIND_PLAIN_MULTIPLY_ELEMENT));
    end
  end

endmodule // dsp_multiply_accumulate_block

// File: verif/dsp_mac_checker.sv
// Purpose: Port assertions for the arithmetic slice.
// Assumes: dsp_mac_map.vh on the include path.
// Notes:   Bound into every slice instance.
`timescale 1ns/1ps
`include "dsp_mac_map.vh"
module dsp_mac_checker (
  input wire         core_clk,
  input wire         sys_rst,
  input wire [1:0]   cfg_kind,
  input wire [1:0]   cfg_width,
  input wire         cfg_signed,
  input wire         cfg_sub,
  input wire         dyn_en,
  input wire [71:0]  a_in,
  input wire [71:0]  b_in,
  input wire [2:0]   stage_use,
  input wire [143:0] result_out,
  input wire [1:0]   overflow_out,
  input wire         cfg_error
);
  wire plain = stage_use == 3'h0 && !dyn_en && !cfg_signed;
  wire m36   = plain && cfg_kind == `KIND_PLAIN_MULTIPLY_ELEMENT && cfg_width == `WSEL_36;
  wire p9    = plain && cfg_kind == `KIND_ADDSUB && cfg_width == `WSEL_9 && !cfg_sub;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ===================================================
  // Assertions
  rst_clear_a: assert property (disable iff (1'b0)
    sys_rst |=> result_out == 144'h0 && overflow_out == 2'h0 && !cfg_error)
    else $error("outputs not cleared by reset");
  ovf_single_a: assert property (overflow_out != 2'h0 |=> overflow_out == 2'h0)
    else $error("overflow longer than one cycle");
  ovf_mac_a: assert property (cfg_kind != `KIND_MAC |=> overflow_out == 2'h0)
    else $error("overflow outside accumulate kind");
  width_bad_a: assert property (cfg_width == 2'h3 [*2] |=> cfg_error)
    else $error("illegal width not flagged");
  wide_combo_a: assert property (
    (cfg_width == `WSEL_36 && cfg_kind != `KIND_PLAIN_MULTIPLY_ELEMENT) [*2] |=> cfg_error)
    else $error("wide non-multiply not flagged");
  width_ok_a: assert property (cfg_width < `WSEL_36 [*2] |=> !cfg_error)
    else $error("legal config flagged");
  plain_multiply_element_bypass_a: assert property ($past(!sys_rst, 2) && $past(m36) |->
    result_out[71:0] == $past(a_in[35:0]) * $past(b_in[35:0]))
    else $error("wide product wrong");
  pair_sum_a: assert property ($past(!sys_rst, 2) && $past(p9) |->
    result_out[35:0] == $past(a_in[8:0]) * $past(b_in[8:0])
      + $past(a_in[17:9]) * $past(b_in[17:9]))
    else $error("pair sum wrong");
endmodule // dsp_mac_checker

bind dsp_multiply_accumulate_block dsp_mac_checker dsp_mac_checker_i (
  .core_clk, .sys_rst, .cfg_kind, .cfg_width, .cfg_signed, .cfg_sub, .dyn_en,
  .a_in, .b_in, .stage_use, .result_out, .overflow_out, .cfg_error);

// File: verif/fabric_operand_model.sv
// Purpose: Fabric side: operand packing and a stage clock source.
// Assumes: 8-bit operands widened to the selected lane width.
// Notes:   Source idles low between requested pulses.
`timescale 1ns/1ps
module fabric_operand_model (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        go,
  input  wire        sgn,
  input  wire [1:0]  wsel,
  input  wire [7:0]  a8,
  input  wire [7:0]  b8,
  output wire [71:0] a_in,
  output wire [71:0] b_in,
  output wire        src_clk
);
  reg [2:0] cnt_reg;
  // ===================================================
  // Operand lanes
  function automatic [71:0] lanes(input [7:0] v, input s, input [1:0] w);
    reg [35:0] x;
    begin
      x = s ? {{28{v[7]}}, v} : {28'h0, v};
      lanes = w == 2'h0 ? {8{x[8:0]}} : w == 2'h1 ? {4{x[17:0]}} : {2{x}};
    end
  endfunction
  assign a_in = lanes(a8, sgn, wsel);
  assign b_in = lanes(b8, sgn, wsel);
  // ===================================================
  // Stage clock: two cycles high per go, then low until the next go
  always @(posedge core_clk) begin
    if (sys_rst) cnt_reg <= 3'h0;
    else if (go) cnt_reg <= 3'h4;
    else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
  end
  assign src_clk = cnt_reg >= 3'h3;
endmodule // fabric_operand_model

// File: verif/dsp_multiply_accumulate_block_bench.sv
// Purpose: Self-checking bench for the arithmetic slice.
// Assumes: Parallel operands come from the fabric model, shift-in operands from the bench.
// Notes:   Table rows run bypassed; accumulate runs staged.
`timescale 1ns/1ps
`include "dsp_mac_map.vh"
module dsp_multiply_accumulate_block_bench;
  typedef struct {logic [1:0] k, w; logic sg, dy, ds, dsub, sub; logic [7:0] a, b;
    logic [143:0] v; int lw, n;} row_t;
  reg         core_clk = 0, sys_rst = 1, go = 0, sgn = 0, acc_load = 0;
  reg [1:0]   cfg_kind = 0, cfg_width = 0, last_ovf = 0;
  reg         cfg_signed = 0, cfg_sub = 0, dyn_en = 0, sign_ctrl = 0, addsub_ctrl = 0;
  reg [7:0]   a8 = 0, b8 = 0;
  reg [2:0]   stage_use = 0;
  reg [5:0]   clk_sel = 0, ce_sel = 0, rst_sel = 0;
  reg [3:0]   ce_src = 4'hf, rst_src = 4'h0;
  reg         cfg_serial = 1'b0, serial_ctrl = 1'b0;
  reg [35:0]  a_shift_in = 36'h0, b_shift_in = 36'h0;
  reg [143:0] acc_init = {2{72'hfffffffffffffffff1}}, e, m;
  wire        src_clk, cfg_error;
  wire [71:0] a_in, b_in;
  wire [143:0] result_out;
  wire [1:0]  overflow_out;
  int         n_mismatch = 0, total_checks = 0, n_ovf = 0;
  // kind width sign dyn dynsign dynsub sub a b lane lanebits lanes
  row_t rows [8] = '{'{0,0,1,1,0,0,0,8'hfe,8'h5,144'h9f6,18,8},
    '{0,1,1,0,0,0,0,8'hfe,8'hfd,144'd6,36,4}, '{0,2,0,0,0,0,0,8'h3,8'h5,144'd15,72,1},
    '{2,0,0,0,0,0,0,8'h3,8'h5,144'd30,36,4}, '{2,0,0,0,0,0,1,8'h3,8'h5,144'd0,36,4},
    '{2,1,1,1,1,0,1,8'hfe,8'h5,-144'd20,72,2}, '{3,0,0,0,0,0,0,8'h3,8'h5,144'd60,72,2},
    '{3,1,1,0,0,0,0,8'hfe,8'h5,-144'd40,144,1}};

  dsp_multiply_accumulate_block dsp_multiply_accumulate_block_i (
    .core_clk, .sys_rst, .cfg_kind, .cfg_width, .cfg_signed, .cfg_sub, .cfg_serial,
    .dyn_en, .sign_ctrl, .addsub_ctrl, .serial_ctrl, .acc_load, .acc_init, .a_in,
    .b_in, .a_shift_in, .b_shift_in, .stage_use, .clk_sel, .ce_sel, .rst_sel,
    .stage_clock_source_0(src_clk), .stage_clock_source_1(src_clk),
    .stage_clock_source_2(src_clk), .stage_clock_source_3(src_clk),
    .stage_enable_source_0(ce_src[0]), .stage_enable_source_1(ce_src[1]),
    .stage_enable_source_2(ce_src[2]), .stage_enable_source_3(ce_src[3]),
    .stage_reset_source_0(rst_src[0]), .stage_reset_source_1(rst_src[1]),
    .stage_reset_source_2(rst_src[2]), .stage_reset_source_3(rst_src[3]),
    .result_out, .overflow_out, .cfg_error);
  fabric_operand_model fabric_operand_model_i (.core_clk, .sys_rst, .go, .sgn,
    .wsel(cfg_width), .a8, .b8, .a_in, .b_in, .src_clk);

  // ===================================================
  // Clock, overflow watch, watchdog
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (!sys_rst && overflow_out !== 2'h0) begin
    n_ovf++;
    last_ovf = overflow_out;
  end
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
  // ===================================================
  // Tasks
  task automatic chk(input string nm, input logic [143:0] ex, input logic [143:0] got);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rise();
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ===================================================
  // Sequence
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    chk("reset_result", 0, result_out);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge core_clk);
      {cfg_kind, cfg_width, sgn, cfg_signed, dyn_en, sign_ctrl, addsub_ctrl, cfg_sub, a8, b8}
        <= {rows[i].k, rows[i].w, rows[i].sg, rows[i].sg, rows[i].dy, rows[i].ds,
            rows[i].dsub, rows[i].sub, rows[i].a, rows[i].b};
      for (int j = 0; j < 144; j++) begin
        m[j] = j < rows[i].lw * rows[i].n;
        e[j] = m[j] & rows[i].v[j % rows[i].lw];
      end
      repeat (3) @(posedge core_clk);
      #1;
      chk("row_result", e, result_out & m);
      chk("row_err", 0, cfg_error);
    end
    @(posedge core_clk);
    {cfg_kind, cfg_width, sgn, dyn_en, sign_ctrl, serial_ctrl} <= {`KIND_PLAIN_MULTIPLY_ELEMENT, `WSEL_18, 4'h5};
    {stage_use, a_shift_in, b_shift_in} <= {3'h1, 36'h3, 36'h5};
    rise();
    chk("serial_first", {108'h0, 36'hf}, result_out);
    rise();
    chk("serial_shift", {72'h0, 36'hf, 36'hf}, result_out);
    @(posedge core_clk);
    {cfg_kind, cfg_width, sgn, cfg_signed, dyn_en, cfg_sub, a8, b8}
      <= {`KIND_MAC, `WSEL_18, 4'h0, 8'h3, 8'h5};
    stage_use <= 3'h7;
    serial_ctrl <= 1'b0;
    acc_load <= 1'b1;
    repeat (3) rise();
    chk("acc_loaded", acc_init, result_out);
    @(posedge core_clk);
    acc_load <= 1'b0;
    rise();
    chk("acc_wrap", 0, result_out);
    chk("ovf_bits", 3, last_ovf);
    rise();
    chk("acc_add", {2{72'hf}}, result_out);
    chk("ovf_count", 1, n_ovf);
    @(posedge core_clk);
    dyn_en <= 1'b1;
    addsub_ctrl <= 1'b1;
    repeat (2) rise();
    chk("acc_sub", acc_init, result_out);
    chk("ovf_borrow", 2, n_ovf);
    @(posedge core_clk);
    ce_sel <= 6'h15;
    ce_src <= 4'hd;
    rise();
    chk("acc_held", acc_init, result_out);
    @(posedge core_clk);
    rst_sel <= 6'h2a;
    rst_src <= 4'h4;
    rise();
    chk("stage_reset", 0, result_out);
    @(posedge core_clk);
    {ce_sel, rst_sel, sign_ctrl, addsub_ctrl, acc_load} <= {12'h0, 3'h5};
    acc_init <= {2{72'h7ffffffffffffffff1}};
    repeat (3) rise();
    @(posedge core_clk);
    acc_load <= 1'b0;
    rise();
    chk("acc_signed_wrap", {2{72'h800000000000000000}}, result_out);
    chk("ovf_signed", 3, n_ovf);
    @(posedge core_clk);
    cfg_width <= `WSEL_36;
    repeat (4) @(posedge core_clk);
    #1;
    chk("wide_mac_err", 1, cfg_error);
    @(posedge core_clk);
    cfg_width <= 2'h3;
    repeat (4) @(posedge core_clk);
    #1;
    chk("bad_width_err", 1, cfg_error);
    report_and_stop();
  end
endmodule // dsp_multiply_accumulate_block_bench
